// ### psr_consts.vh
// Behaviour
// - device takes din and launches dout on each rising serial clock edge
// - dout carries result or calibration word per last instruction, plus status
// - seven instructions: pressure, temperature, four word reads, reset
// - each instruction but reset opens with three high bits before the setup field
// - each instruction but reset closes with three low bits after the setup field
// - four-bit setup field selects pressure, temperature or word read
// - conversion start acknowledged by dout going low to high
// - end of conversion shown by dout going high to low, clock low
// - seventeen clocks read the sixteen-bit result after conversion end
// - readout survives clock pauses anywhere without losing bits
// - 21-bit reset pattern seen in any state returns to idle
// - pressure and temperature come as 16-bit unsigned from one converter
// - 64 calibration bits read as four 16-bit words
// - word one: coef one and coef two top; word two: coef two low, coef five top
// - word three: coef three, coef five low; word four: coef four, coef six
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

`define PSR_START_LEN      3
`define PSR_FRAME_LEN      5'h07
`define PSR_SETUP_MSB      6
`define PSR_SETUP_LSB      3
`define PSR_STOP_MSB       2
`define PSR_STOP_LSB       0
`define PSR_RESET_LEN      21
`define PSR_RESET_PATTERN  21'h155540

`define PSR_SETUP_PRESS    4'hA
`define PSR_SETUP_TEMP     4'h9
`define PSR_SETUP_CALIBRATION_WORD_ONE    4'h5
`define PSR_SETUP_CALIBRATION_WORD_TWO    4'h6
`define PSR_SETUP_CALIBRATION_WORD_THREE    4'h3
`define PSR_SETUP_CALIBRATION_WORD_FOUR    4'hC

`define PSR_ACK_CLOCKS     5'h02
`define PSR_DATA_BITS      5'h10
`define PSR_READ_CLOCKS    5'h11

`define PSR_MCLK_HZ        32768
`define PSR_CONV_TIME_US   35000
`define PSR_CONV_MCLKS     ((`PSR_CONV_TIME_US * `PSR_MCLK_HZ) / 1000000)

`define PSR_RESET_WORD     16'h0000

`endif

// ### psr_host.sv
`timescale 1ns/100ps
`include "psr_consts.vh"
module psr_host (
   output logic sclk,
   output logic din,
   input  logic dout
);
   // serial clock stands low between frames
   initial begin
      sclk = 1'b0;
      din  = 1'b0;
   end
   task automatic bit_io(input logic b, output logic q);
      din = b;
      #20 sclk = 1'b1;
      #40 sclk = 1'b0;
      #20 q = dout;
   endtask
   task automatic send(input logic [20:0] v, input int n, output logic q);
      for (int i = n - 1; i >= 0; i--) begin
         bit_io(v[i], q);
      end
      din = 1'b0;
   endtask
   task automatic frame(input logic [3:0] code, output logic q);
      send({11'h000, 3'h7, code, 3'h0}, 10, q);
   endtask
   // dout is meaningless while the pattern goes out, so it is dropped
   task automatic reset_seq;
      logic q;
      send(`PSR_RESET_PATTERN, 21, q);
   endtask
   task automatic read17(input int pause, output logic [16:0] r);
      for (int i = 16; i >= 0; i--) begin
         bit_io(1'b0, r[i]);
         if (i == 9) #(pause);
      end
   endtask
   // no fixed delay: the dout fall ends the wait, or 20000 polls of 10 ns, clock held low
   task automatic wait_end(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 20000 && !ok; i++) begin
         #10 ok = !dout;
      end
   endtask
endmodule // psr_host

// ### psr_readout.v
`timescale 1ns/100ps
`include "psr_consts.vh"
module psr_readout #(
   parameter [12:0] COEF_ONE   = 13'h0000,
   parameter [12:0] COEF_TWO   = 13'h0000,
   parameter [9:0]  COEF_THREE = 10'h000,
   parameter [8:0]  COEF_FOUR  = 9'h000,
   parameter [11:0] COEF_FIVE  = 12'h000,
   parameter [6:0]  COEF_SIX   = 7'h00
) (
   clk_sys,
   rst_n,
   sclk,
   din,
   mclk,
   raw_pressure_value,
   raw_temperature_value,
   dout,
   conv_busy
);
   input  wire        clk_sys;
   input  wire        rst_n;
   input  wire        sclk;
   input  wire        din;
   input  wire        mclk;
   input  wire [15:0] raw_pressure_value;
   input  wire [15:0] raw_temperature_value;
   output wire        dout;
   output wire        conv_busy;

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_FRAME = 3'h1;
   localparam [2:0] ST_ACK   = 3'h2;
   localparam [2:0] ST_CONV  = 3'h3;
   localparam [2:0] ST_SHIFT = 3'h4;

   localparam integer CONV_MCLKS = `PSR_CONV_MCLKS;
   // count is cut to the counter width on purpose; it stays below 2048
   localparam [10:0]  CONV_LAST  = CONV_MCLKS[10:0] - 11'h001;

   // calibration words packed from the factory coefficients
   wire [15:0] calibration_word_one;
   wire [15:0] calibration_word_two;
   wire [15:0] calibration_word_three;
   wire [15:0] calibration_word_four;

   assign calibration_word_one   = {COEF_ONE, COEF_TWO[12:10]};
   assign calibration_word_two   = {COEF_TWO[9:0], COEF_FIVE[11:6]};
   assign calibration_word_three = {COEF_THREE, COEF_FIVE[5:0]};
   assign calibration_word_four  = {COEF_FOUR, COEF_SIX};

   wire        sclk_s;
   wire        din_s;
   wire        mclk_s;

   psr_sync u_sync_sclk (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (sclk),
      .sync_out (sclk_s)
   );

   psr_sync u_sync_din (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (din),
      .sync_out (din_s)
   );

   // master clock is slow enough to be sampled as a plain level
   psr_sync u_sync_mclk (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (mclk),
      .sync_out (mclk_s)
   );

   reg         sclk_d_reg;
   reg         mclk_d_reg;
   wire        sclk_rise;
   wire        mclk_rise;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_reg <= 1'b0;
         mclk_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         mclk_d_reg <= mclk_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_reg;
   assign mclk_rise = mclk_s & ~mclk_d_reg;

   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [20:0] hist_reg;
   reg  [20:0] hist_next;
   reg  [4:0]  cnt_reg;
   reg  [4:0]  cnt_next;
   reg         sel_temp_reg;
   reg         sel_temp_next;
   reg  [15:0] shift_reg;
   reg  [15:0] shift_next;
   reg         dout_reg;
   reg         dout_next;
   reg         conv_go;
   reg         conv_abort;
   // bits taken since entering idle, saturating at two
   reg  [1:0]  fresh_reg;
   reg  [1:0]  fresh_next;

   reg  [10:0] conv_cnt_reg;
   reg  [10:0] conv_cnt_next;
   reg         conv_busy_reg;
   reg         conv_busy_next;
   reg         conv_done_reg;
   reg         conv_done_next;
   reg  [15:0] result_reg;
   reg  [15:0] result_next;

   wire [20:0] hist_shift;
   wire        reset_seen;
   wire [3:0]  setup_code;
   wire        stop_ok;
   wire        start_seen;

   // din history, one bit per rising serial clock edge
   assign hist_shift = {hist_reg[19:0], din_s};
   // pattern watch runs in every state so a lost frame always recovers
   assign reset_seen = sclk_rise &&
                       (hist_shift == `PSR_RESET_PATTERN);
   assign start_seen = (hist_shift[`PSR_START_LEN-1:0] == 3'h7);
   assign setup_code = hist_shift[`PSR_SETUP_MSB:`PSR_SETUP_LSB];
   assign stop_ok    = (hist_shift[`PSR_STOP_MSB:`PSR_STOP_LSB]
                        == 3'h0);

   reg         code_press;
   reg         code_temp;
   reg         code_word;
   reg  [15:0] code_word_value;

   // setup decode apart from the engine; an unknown code selects nothing
   // kept combinational so the engine acts on the completing edge itself
   always @* begin
      code_press      = 1'b0;
      code_temp       = 1'b0;
      code_word       = 1'b0;
      code_word_value = `PSR_RESET_WORD;
      if (setup_code == `PSR_SETUP_PRESS) begin
         code_press = 1'b1;
      end else if (setup_code == `PSR_SETUP_TEMP) begin
         code_temp = 1'b1;
      end else if (setup_code == `PSR_SETUP_CALIBRATION_WORD_ONE) begin
         code_word       = 1'b1;
         code_word_value = calibration_word_one;
      end else if (setup_code == `PSR_SETUP_CALIBRATION_WORD_TWO) begin
         code_word       = 1'b1;
         code_word_value = calibration_word_two;
      end else if (setup_code == `PSR_SETUP_CALIBRATION_WORD_THREE) begin
         code_word       = 1'b1;
         code_word_value = calibration_word_three;
      end else if (setup_code == `PSR_SETUP_CALIBRATION_WORD_FOUR) begin
         code_word       = 1'b1;
         code_word_value = calibration_word_four;
      end
   end

   always @* begin
      hist_next = hist_reg;
      if (sclk_rise) begin
         hist_next = hist_shift;
      end
      // a matched pattern is flushed so its tail cannot start a frame
      if (reset_seen) begin
         hist_next = 21'h000000;
      end
   end

   // protocol engine, one step per rising serial clock edge, or at conversion end in ST_CONV
   always @* begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      sel_temp_next = sel_temp_reg;
      shift_next    = shift_reg;
      dout_next     = dout_reg;
      fresh_next    = fresh_reg;
      conv_go       = 1'b0;
      conv_abort    = 1'b0;
      if (reset_seen) begin
         state_next = ST_IDLE;
         cnt_next   = 5'h00;
         shift_next = `PSR_RESET_WORD;
         dout_next  = 1'b0;
         conv_abort = 1'b1;
         fresh_next = 2'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (sclk_rise) begin
                  // stale bits of an earlier frame must not form a start
                  if (!fresh_reg[1]) begin
                     fresh_next = fresh_reg + 2'h1;
                  end
                  if (start_seen && fresh_reg[1]) begin
                     state_next = ST_FRAME;
                     cnt_next   = 5'h00;
                     fresh_next = 2'h0;
                  end
               end
            end
            ST_FRAME: begin
               if (sclk_rise) begin
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == `PSR_FRAME_LEN - 5'h01) begin
                     cnt_next   = 5'h00;
                     state_next = ST_IDLE;
                     if (stop_ok) begin
                        if (code_press || code_temp) begin
                           state_next    = ST_ACK;
                           sel_temp_next = code_temp;
                           dout_next     = 1'b1;
                           conv_go       = 1'b1;
                        end else if (code_word) begin
                           state_next = ST_SHIFT;
                           shift_next = code_word_value;
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               // acknowledge level stays up through the two extra clocks
               if (sclk_rise) begin
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == `PSR_ACK_CLOCKS - 5'h01) begin
                     cnt_next   = 5'h00;
                     state_next = ST_CONV;
                  end
               end
            end
            ST_CONV: begin
               // stray clocks here are ignored; only completion or the reset pattern moves on
               if (conv_done_reg) begin
                  state_next = ST_SHIFT;
                  shift_next = result_reg;
                  dout_next  = 1'b0;
                  cnt_next   = 5'h00;
               end
            end
            ST_SHIFT: begin
               // position is held in cnt_reg, so a paused clock loses nothing
               if (sclk_rise) begin
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg < `PSR_DATA_BITS) begin
                     dout_next  = shift_reg[15];
                     shift_next = {shift_reg[14:0], 1'b0};
                  end else begin
                     dout_next  = 1'b0;
                     cnt_next   = 5'h00;
                     state_next = ST_IDLE;
                  end
               end
            end
            default: begin
               state_next = ST_IDLE;
               cnt_next   = 5'h00;
               fresh_next = 2'h0;
               dout_next  = 1'b0;
            end
         endcase
      end
   end

   // converter timing, counted in master clock periods
   always @* begin
      conv_cnt_next  = conv_cnt_reg;
      conv_busy_next = conv_busy_reg;
      conv_done_next = conv_done_reg;
      result_next    = result_reg;
      if (conv_abort) begin
         conv_busy_next = 1'b0;
         conv_done_next = 1'b0;
      end else if (conv_go) begin
         conv_cnt_next  = 11'h000;
         conv_busy_next = 1'b1;
         conv_done_next = 1'b0;
      end else if (conv_busy_reg && mclk_rise) begin
         conv_cnt_next = conv_cnt_reg + 11'h001;
         if (conv_cnt_reg == CONV_LAST) begin
            conv_busy_next = 1'b0;
            conv_done_next = 1'b1;
            // one shared converter, the selection picks the channel
            if (sel_temp_reg) begin
               result_next = raw_temperature_value;
            end else begin
               result_next = raw_pressure_value;
            end
         end
      end else if (state_reg == ST_CONV && conv_done_reg) begin
         conv_done_next = 1'b0;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         hist_reg     <= 21'h000000;
         cnt_reg      <= 5'h00;
         sel_temp_reg <= 1'b0;
         shift_reg    <= `PSR_RESET_WORD;
         dout_reg     <= 1'b0;
         fresh_reg    <= 2'h0;
      end else begin
         state_reg    <= state_next;
         hist_reg     <= hist_next;
         cnt_reg      <= cnt_next;
         sel_temp_reg <= sel_temp_next;
         shift_reg    <= shift_next;
         dout_reg     <= dout_next;
         fresh_reg    <= fresh_next;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt_reg  <= 11'h000;
         conv_busy_reg <= 1'b0;
         conv_done_reg <= 1'b0;
         result_reg    <= `PSR_RESET_WORD;
      end else begin
         conv_cnt_reg  <= conv_cnt_next;
         conv_busy_reg <= conv_busy_next;
         conv_done_reg <= conv_done_next;
         result_reg    <= result_next;
      end
   end

   assign dout      = dout_reg;
   assign conv_busy = conv_busy_reg;
endmodule // psr_readout

// ### psr_readout_sva.sv
`timescale 1ns/100ps
`include "psr_consts.vh"
module psr_readout_sva (
   input logic        clk_sys,
   input logic        rst_n,
   input logic        sclk,
   input logic        din,
   input logic        mclk,
   input logic [15:0] raw_pressure_value,
   input logic [15:0] raw_temperature_value,
   input logic        dout,
   input logic        conv_busy
);
   localparam int CONV = `PSR_CONV_MCLKS;
   logic        sclk_reg;
   logic        mclk_reg;
   logic [3:0]  since_reg;
   logic [20:0] hist_reg;
   logic [11:0] mcnt_reg;
   logic        rise;
   assign rise = sclk && !sclk_reg;
   // since_reg saturates at F: a quiet link, where only conversion end may move dout
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_reg  <= 1'b0;
         mclk_reg  <= 1'b0;
         since_reg <= 4'hF;
         hist_reg  <= 21'h000000;
         mcnt_reg  <= 12'h000;
      end else begin
         sclk_reg <= sclk;
         mclk_reg <= mclk;
         if (rise) begin
            since_reg <= 4'h0;
            hist_reg  <= {hist_reg[19:0], din};
         end else if (since_reg != 4'hF) begin
            since_reg <= since_reg + 4'h1;
         end
         if (!conv_busy) begin
            mcnt_reg <= 12'h000;
         end else if (mclk && !mclk_reg) begin
            mcnt_reg <= mcnt_reg + 12'h001;
         end
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_idle3;
      (!dout && !conv_busy) [*3];
   endsequence
   sequence s_end;
      !sclk ##1 $fell(dout);
   endsequence
   a_reset_idle: assert property ($rose(rst_n) |-> s_idle3)
      else $error("dout or busy active after reset");
   a_dout_on_rise: assert property ($changed(dout) |-> since_reg <= 4'h5
      || ($past(conv_busy, 2) && !$past(conv_busy)))
      else $error("dout moved away from a serial rising edge");
   a_end_marker: assert property ($fell(conv_busy) && since_reg == 4'hF
      |-> s_end) else $error("conversion end not shown on dout");
   a_ack_frame: assert property ($rose(conv_busy) |-> (hist_reg[9:0] ==
      10'h3D0 || hist_reg[9:0] == 10'h3C8) ##[0:1] dout)
      else $error("conversion start without valid frame or ack");
   a_busy_dout: assert property (conv_busy && $past(conv_busy) &&
      since_reg == 4'hF |-> dout) else $error("dout low while busy");
   a_busy_min: assert property ($fell(conv_busy) && since_reg == 4'hF
      |-> mcnt_reg >= CONV - 2) else $error("conversion ended early");
   a_busy_max: assert property (conv_busy |-> mcnt_reg <= CONV + 1)
      else $error("conversion ran too long");
   a_reset_pattern: assert property (rise && {hist_reg[19:0], din} ==
      `PSR_RESET_PATTERN |-> ##5 (!conv_busy && !dout))
      else $error("reset pattern did not return to idle");
endmodule // psr_readout_sva
bind psr_readout psr_readout_sva psr_readout_sva_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .din(din), .mclk(mclk),
   .raw_pressure_value(raw_pressure_value),
   .raw_temperature_value(raw_temperature_value),
   .dout(dout), .conv_busy(conv_busy));

// ### psr_sync.v
`timescale 1ns/100ps
module psr_sync (
   clk_sys,
   rst_n,
   async_in,
   sync_out
);
   input  wire clk_sys;
   input  wire rst_n;
   input  wire async_in;
   output wire sync_out;

   reg         meta_reg;
   reg         hold_reg;

   // first stage feeds only the second stage
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         hold_reg <= meta_reg;
      end
   end

   assign sync_out = hold_reg;
endmodule // psr_sync

// ### psr_tb.sv
`timescale 1ns/100ps
`include "psr_consts.vh"
module testbench;
   localparam logic [12:0] C1 = 13'h1ABC;
   localparam logic [12:0] C2 = 13'h0F35;
   localparam logic [9:0]  C3 = 10'h2D7;
   localparam logic [8:0]  C4 = 9'h15A;
   localparam logic [11:0] C5 = 12'hB6C;
   localparam logic [6:0]  C6 = 7'h4B;
   logic        clk_sys, rst_n, sclk, din, mclk, dout, conv_busy, q, ok;
   logic [15:0] raw_pressure_value, raw_temperature_value;
   logic [16:0] r;
   logic [15:0] words [4];
   logic [3:0]  codes [4];
   int          err_count, check_count;
   psr_readout #(.COEF_ONE(C1), .COEF_TWO(C2), .COEF_THREE(C3),
      .COEF_FOUR(C4), .COEF_FIVE(C5), .COEF_SIX(C6)) psr_readout_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .din(din), .mclk(mclk),
      .raw_pressure_value(raw_pressure_value),
      .raw_temperature_value(raw_temperature_value),
      .dout(dout), .conv_busy(conv_busy));
   psr_host psr_host_i (.sclk(sclk), .din(din), .dout(dout));
   always #5 clk_sys = ~clk_sys;
   // fast converter clock keeps a conversion near 7000 system cycles
   always #30 mclk = ~mclk;
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic calib_reads;
      words = '{{C1, C2[12:10]}, {C2[9:0], C5[11:6]}, {C3, C5[5:0]}, {C4, C6}};
      codes = '{`PSR_SETUP_CALIBRATION_WORD_ONE, `PSR_SETUP_CALIBRATION_WORD_TWO, `PSR_SETUP_CALIBRATION_WORD_THREE,
         `PSR_SETUP_CALIBRATION_WORD_FOUR};
      for (int i = 0; i < 4; i++) begin
         psr_host_i.frame(codes[i], q);
         check({16'h0000, q}, 17'h00000);
         psr_host_i.read17(i * 300, r);
         check(r, {words[i], 1'b0});
      end
   endtask
   task automatic conversions;
      for (int k = 0; k < 2; k++) begin
         psr_host_i.reset_seq();
         psr_host_i.frame(k ? `PSR_SETUP_TEMP : `PSR_SETUP_PRESS, q);
         check({16'h0000, q}, 17'h00001);
         check({16'h0000, conv_busy}, 17'h00001);
         psr_host_i.bit_io(1'b0, q);
         psr_host_i.bit_io(1'b0, q);
         check({16'h0000, q}, 17'h00001);
         psr_host_i.wait_end(ok);
         check({16'h0000, ok}, 17'h00001);
         if (!ok) test_done();
         check({16'h0000, conv_busy}, 17'h00000);
         psr_host_i.read17(0, r);
         check(r, {k ? raw_temperature_value : raw_pressure_value, 1'b0});
      end
   endtask
   task automatic abort_and_refuse;
      psr_host_i.frame(`PSR_SETUP_PRESS, q);
      psr_host_i.bit_io(1'b0, q);
      psr_host_i.reset_seq();
      check({15'h0000, conv_busy, dout}, 17'h00000);
      psr_host_i.send({11'h000, 3'h7, `PSR_SETUP_PRESS, 3'h1}, 10, q);
      check({15'h0000, conv_busy, q}, 17'h00000);
      psr_host_i.frame(`PSR_SETUP_CALIBRATION_WORD_FOUR, q);
      psr_host_i.read17(0, r);
      check(r, {C4, C6, 1'b0});
   endtask
   initial begin
      clk_sys = 1'b0;
      mclk = 1'b0;
      rst_n = 1'b0;
      raw_pressure_value = 16'hC3A5;
      raw_temperature_value = 16'h5A1E;
      err_count = 0;
      check_count = 0;
      repeat (20) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      // keep every host edge off the system clock edge
      #1;
      calib_reads();
      conversions();
      abort_and_refuse();
      test_done();
   end
endmodule // testbench
